// >>> hdl/scb_pkg.sv
// Behaviour
// - take configuration from the parallel pin group
// - pin levels refresh the parallel configuration
// - after reset, pins steer until serial event
// - first serial event switches to serial values
// - pins ignored after takeover until reset
// - serial registers start from their own defaults
// - every serial register readable and writable over I2C
// - three strap pins form low address bits
// - fast modes: enable, mode, source; reset 0x40
// - receiver settings bit 0, default termination on
// - sixteen termination pulse bits over two registers
// - sixteen equalizer bits over two registers, zero
// - seven-bit address, fixed upper nibble, MSB first
// - mode code 11 keeps the previous mode
// - reset restores all register defaults
// - parallel control forces side path quad mode
`default_nettype none
package scb_pkg;
  // register offsets
  localparam logic [7:0] OFS_FAST_MODES = 8'h00;
  localparam logic [7:0] OFS_SIDE_MODES = 8'h01;
  localparam logic [7:0] OFS_RX_SET = 8'h10;
  localparam logic [7:0] OFS_PULSE_LO = 8'h11;
  localparam logic [7:0] OFS_PULSE_HI = 8'h12;
  localparam logic [7:0] OFS_EQ_LO = 8'h13;
  localparam logic [7:0] OFS_EQ_HI = 8'h14;
  localparam logic [7:0] OFS_TX_SET = 8'h20;
  // values after reset
  localparam logic [7:0] RST_FAST_MODES = 8'h40;
  localparam logic [7:0] RST_SIDE_MODES = 8'h40;
  localparam logic [7:0] RST_RX_SET = 8'h01;
  localparam logic [7:0] RST_PULSE = 8'h00;
  localparam logic [7:0] RST_EQ = 8'h00;
  localparam logic [7:0] RST_TX_SET = 8'h03;
  // writable bits, reserved bits read zero
  localparam logic [7:0] MASK_MODES = 8'h7F;
  localparam logic [7:0] MASK_RX_SET = 8'h01;
  localparam logic [7:0] MASK_TX_SET = 8'h0F;
  // field positions
  localparam int EN_BIT = 6;
  localparam int MODE_HI = 5;
  localparam int MODE_LO = 4;
  localparam int SRC_HI = 3;
  localparam int PRE_HI = 3;
  localparam int PRE_LO = 2;
  localparam int OTERM_BIT = 1;
  localparam int OCUR_BIT = 0;
  // switching mode codes
  localparam logic [1:0] MODE_QUAD = 2'h0;
  localparam logic [1:0] MODE_ILLEGAL = 2'h3;
  // slave address upper nibble
  localparam logic [3:0] ADDR_FIXED = 4'h9;
  // bits per I2C byte
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // synchroniser width and idle levels: scl, sda high, others low
  localparam int PIN_W = 13;
  localparam logic [PIN_W-1:0] PIN_RST = 13'h1800;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_REG, ST_RACK_REG, ST_WDATA, ST_WACK, ST_RDATA, ST_RACK
  } scb_i2c_e;

  typedef struct packed {
    logic fast_path_enable;
    logic [1:0] fast_path_switch_mode;
    logic [3:0] fast_path_source_select;
    logic side_path_enable;
    logic [1:0] side_path_switch_mode;
    logic [3:0] side_path_source_select;
    logic input_termination_select;
    logic [15:0] termination_pulse_select;
    logic [15:0] equalizer_level_select;
    logic [1:0] output_preemphasis_level;
    logic output_termination_select;
    logic output_current_level;
  } scb_cfg_s;
endpackage
`default_nettype wire

// >>> hdl/scb_regbank.sv
`default_nettype none
module scb_regbank
  import scb_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe_n,
  input wire logic i_slave_addr_strap_bit2,
  input wire logic i_slave_addr_strap_bit1,
  input wire logic i_slave_addr_strap_bit0,
  input wire logic i_par_switch_enable_pin,
  input wire logic [1:0] i_par_channel_select_pins,
  input wire logic i_par_equalizer_pin,
  input wire logic [1:0] i_par_preemphasis_pins,
  input wire logic i_par_output_termination_pin,
  input wire logic i_par_output_current_pin,
  output var scb_cfg_s o_cfg,
  output logic o_serial_mode
);

  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] sync1;
  logic [PIN_W-1:0] sync2;
  logic [PIN_W-1:0] sync3;
  logic [PIN_W-1:0] pin_f;
  logic scl_f, sda_f, scl_q, sda_q;
  logic [2:0] strap_f;
  logic pf_en, pf_eq, pf_oto, pf_ocl;
  logic [1:0] pf_ch, pf_pre;
  logic scl_rise, scl_fall, start, stop;
  scb_i2c_e st;
  logic [7:0] shift;
  logic [3:0] cnt;
  logic [7:0] ptr;
  logic rw, nack, addr_hit, wr_stb;
  logic [7:0] rd_byte;
  logic [7:0] fast_modes, side_modes, rx_set, pulse_lo, pulse_hi;
  logic [7:0] eq_lo, eq_hi, tx_set;
  scb_cfg_s par_cfg, ser_cfg;

  assign pin_raw = {i_scl, i_sda, i_slave_addr_strap_bit2, i_slave_addr_strap_bit1,
                    i_slave_addr_strap_bit0, i_par_switch_enable_pin,
                    i_par_channel_select_pins, i_par_equalizer_pin,
                    i_par_preemphasis_pins, i_par_output_termination_pin,
                    i_par_output_current_pin};

  // three-stage synchroniser for every pin
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1 <= PIN_RST;
      sync2 <= PIN_RST;
      sync3 <= PIN_RST;
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // a bit changes only once stages two and three agree
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_f <= PIN_RST;
    end else begin
      pin_f <= (pin_f & (sync2 ^ sync3)) | (sync3 & ~(sync2 ^ sync3));
    end
  end

  assign {scl_f, sda_f, strap_f, pf_en, pf_ch, pf_eq, pf_pre, pf_oto, pf_ocl} = pin_f;

  // previous bus levels for edge and condition detection
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  assign scl_rise = scl_f & ~scl_q;
  assign scl_fall = ~scl_f & scl_q;
  assign start = scl_f & scl_q & sda_q & ~sda_f;
  assign stop = scl_f & scl_q & ~sda_q & sda_f;
  assign addr_hit = (shift[7:1] == {ADDR_FIXED, strap_f});
  assign wr_stb = scl_fall & (st == ST_WDATA) & (cnt == BYTE_BITS);

  // register read multiplexer, unmapped offsets read zero
  always_comb begin
    unique case (ptr)
      OFS_FAST_MODES: rd_byte = fast_modes;
      OFS_SIDE_MODES: rd_byte = side_modes;
      OFS_RX_SET: rd_byte = rx_set;
      OFS_PULSE_LO: rd_byte = pulse_lo;
      OFS_PULSE_HI: rd_byte = pulse_hi;
      OFS_EQ_LO: rd_byte = eq_lo;
      OFS_EQ_HI: rd_byte = eq_hi;
      OFS_TX_SET: rd_byte = tx_set;
      default: rd_byte = 8'h00;
    endcase
  end

  // I2C slave: bits sampled on scl rise, sda changed on scl fall
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= ST_IDLE;
      shift <= 8'h00;
      cnt <= 4'h0;
      ptr <= 8'h00;
      rw <= 1'b0;
      nack <= 1'b0;
      o_sda_oe_n <= 1'b1;
      o_sda_out <= 1'b0;
    end else if (start) begin
      st <= ST_ADDR;
      cnt <= 4'h0;
      o_sda_oe_n <= 1'b1;
    end else if (stop) begin
      st <= ST_IDLE;
      o_sda_oe_n <= 1'b1;
    end else if (scl_rise) begin
      if (st == ST_RACK) begin
        nack <= sda_f;
      end else if (st == ST_ADDR || st == ST_REG || st == ST_WDATA) begin
        shift <= {shift[6:0], sda_f};
        cnt <= 4'(cnt + 4'h1);
      end
    end else if (scl_fall) begin
      unique case (st)
        ST_IDLE: begin
        end
        ST_ADDR: begin
          if (cnt == BYTE_BITS) begin
            cnt <= 4'h0;
            if (addr_hit) begin
              rw <= shift[0];
              o_sda_oe_n <= 1'b0;
              st <= ST_AACK;
            end else begin
              st <= ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          if (rw) begin
            shift <= {rd_byte[6:0], 1'b0};
            o_sda_oe_n <= rd_byte[7];
            cnt <= 4'h1;
            st <= ST_RDATA;
          end else begin
            o_sda_oe_n <= 1'b1;
            st <= ST_REG;
          end
        end
        ST_REG: begin
          if (cnt == BYTE_BITS) begin
            ptr <= shift;
            cnt <= 4'h0;
            o_sda_oe_n <= 1'b0;
            st <= ST_RACK_REG;
          end
        end
        ST_RACK_REG, ST_WACK: begin
          o_sda_oe_n <= 1'b1;
          st <= ST_WDATA;
        end
        ST_WDATA: begin
          if (cnt == BYTE_BITS) begin
            ptr <= 8'(ptr + 8'h01); // auto-increment for bursts
            cnt <= 4'h0;
            o_sda_oe_n <= 1'b0;
            st <= ST_WACK;
          end
        end
        ST_RDATA: begin
          if (cnt == BYTE_BITS) begin
            ptr <= 8'(ptr + 8'h01);
            o_sda_oe_n <= 1'b1;
            st <= ST_RACK;
          end else begin
            o_sda_oe_n <= shift[7];
            shift <= {shift[6:0], 1'b0};
            cnt <= 4'(cnt + 4'h1);
          end
        end
        ST_RACK: begin
          if (nack) begin
            st <= ST_IDLE;
          end else begin
            shift <= {rd_byte[6:0], 1'b0};
            o_sda_oe_n <= rd_byte[7];
            cnt <= 4'h1;
            st <= ST_RDATA;
          end
        end
      endcase
    end
  end

  // sticky takeover flag, set by an acknowledged address, cleared by reset
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_serial_mode <= 1'b0;
    end else if (scl_fall && st == ST_ADDR && cnt == BYTE_BITS && addr_hit) begin
      o_serial_mode <= 1'b1;
    end
  end

  // mode register write keeps old mode on the illegal code
  function automatic logic [7:0] mode_wr(input logic [7:0] old, input logic [7:0] d);
    logic [7:0] v;
    v = d & MASK_MODES;
    if (d[MODE_HI:MODE_LO] == MODE_ILLEGAL) begin
      v[MODE_HI:MODE_LO] = old[MODE_HI:MODE_LO];
    end
    return v;
  endfunction

  // serial configuration registers with their own defaults
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fast_modes <= RST_FAST_MODES;
      side_modes <= RST_SIDE_MODES;
      rx_set <= RST_RX_SET;
      pulse_lo <= RST_PULSE;
      pulse_hi <= RST_PULSE;
      eq_lo <= RST_EQ;
      eq_hi <= RST_EQ;
      tx_set <= RST_TX_SET;
    end else if (wr_stb) begin
      unique case (ptr)
        OFS_FAST_MODES: fast_modes <= mode_wr(fast_modes, shift);
        OFS_SIDE_MODES: side_modes <= mode_wr(side_modes, shift);
        OFS_RX_SET: rx_set <= shift & MASK_RX_SET;
        OFS_PULSE_LO: pulse_lo <= shift;
        OFS_PULSE_HI: pulse_hi <= shift;
        OFS_EQ_LO: eq_lo <= shift;
        OFS_EQ_HI: eq_hi <= shift;
        OFS_TX_SET: tx_set <= shift & MASK_TX_SET;
        default: begin
        end
      endcase
    end
  end

  // serial view of the configuration
  always_comb begin
    ser_cfg.fast_path_enable = fast_modes[EN_BIT];
    ser_cfg.fast_path_switch_mode = fast_modes[MODE_HI:MODE_LO];
    ser_cfg.fast_path_source_select = fast_modes[SRC_HI:0];
    ser_cfg.side_path_enable = side_modes[EN_BIT];
    ser_cfg.side_path_switch_mode = side_modes[MODE_HI:MODE_LO];
    ser_cfg.side_path_source_select = side_modes[SRC_HI:0];
    ser_cfg.input_termination_select = rx_set[0];
    ser_cfg.termination_pulse_select = {pulse_hi, pulse_lo};
    ser_cfg.equalizer_level_select = {eq_hi, eq_lo};
    ser_cfg.output_preemphasis_level = tx_set[PRE_HI:PRE_LO];
    ser_cfg.output_termination_select = tx_set[OTERM_BIT];
    ser_cfg.output_current_level = tx_set[OCUR_BIT];
  end

  // parallel configuration, refreshed from pins until takeover
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      par_cfg <= '0;
    end else if (!o_serial_mode) begin
      par_cfg.fast_path_enable <= pf_en;
      par_cfg.fast_path_switch_mode <= MODE_QUAD;
      par_cfg.fast_path_source_select <= {2'b00, pf_ch};
      par_cfg.side_path_enable <= pf_en;
      par_cfg.side_path_switch_mode <= MODE_QUAD;
      par_cfg.side_path_source_select <= {2'b00, pf_ch};
      par_cfg.input_termination_select <= 1'b1;
      par_cfg.termination_pulse_select <= 16'h0000;
      par_cfg.equalizer_level_select <= {16{pf_eq}};
      par_cfg.output_preemphasis_level <= pf_pre;
      par_cfg.output_termination_select <= pf_oto;
      par_cfg.output_current_level <= pf_ocl;
    end
  end

  // active configuration selects the serial view after takeover
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cfg <= '0;
    end else begin
      o_cfg <= o_serial_mode ? ser_cfg : par_cfg;
    end
  end

  property p_takeover_sticky;
    @(posedge i_clk) disable iff (i_rst)
    o_serial_mode |=> o_serial_mode;
  endproperty
  a_takeover_sticky: assert property (p_takeover_sticky)
    else $error("takeover flag dropped without reset");

  property p_par_follows;
    @(posedge i_clk) disable iff (i_rst)
    !o_serial_mode ##1 !o_serial_mode ##1 1'b1 |->
      o_cfg.output_current_level == $past(pf_ocl, 2) &&
      o_cfg.fast_path_source_select[1:0] == $past(pf_ch, 2);
  endproperty
  a_par_follows: assert property (p_par_follows)
    else $error("parallel pins not reflected in configuration");

  property p_side_quad;
    @(posedge i_clk) disable iff (i_rst)
    !o_serial_mode ##1 1'b1 |-> o_cfg.side_path_switch_mode == MODE_QUAD;
  endproperty
  a_side_quad: assert property (p_side_quad)
    else $error("side path not quad under parallel control");

  property p_serial_drives;
    @(posedge i_clk) disable iff (i_rst)
    o_serial_mode |=> o_cfg.fast_path_source_select == $past(fast_modes[SRC_HI:0])
      && o_cfg.equalizer_level_select == $past({eq_hi, eq_lo});
  endproperty
  a_serial_drives: assert property (p_serial_drives)
    else $error("serial values not driving configuration");

  property p_serial_defaults;
    @(posedge i_clk) disable iff (i_rst)
    $rose(o_serial_mode) |-> rx_set == RST_RX_SET && eq_lo == RST_EQ &&
      fast_modes == RST_FAST_MODES && pulse_hi == RST_PULSE;
  endproperty
  a_serial_defaults: assert property (p_serial_defaults)
    else $error("serial registers not at defaults on takeover");

  property p_illegal_mode;
    @(posedge i_clk) disable iff (i_rst)
    wr_stb && ptr == OFS_FAST_MODES && shift[MODE_HI:MODE_LO] == MODE_ILLEGAL
      |=> $stable(fast_modes[MODE_HI:MODE_LO]);
  endproperty
  a_illegal_mode: assert property (p_illegal_mode)
    else $error("illegal mode code changed the mode");

  property p_write_lands;
    @(posedge i_clk) disable iff (i_rst)
    wr_stb && ptr == OFS_EQ_HI |=> eq_hi == $past(shift);
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("register write lost");

  property p_addr_miss;
    @(posedge i_clk) disable iff (i_rst)
    scl_fall && st == ST_ADDR && cnt == BYTE_BITS && !addr_hit
      |=> st == ST_IDLE && o_sda_oe_n ##1 !$rose(o_serial_mode);
  endproperty
  a_addr_miss: assert property (p_addr_miss)
    else $error("foreign address acknowledged");

  property p_ack_takeover;
    @(posedge i_clk) disable iff (i_rst)
    $rose(st == ST_AACK) |-> o_serial_mode && !o_sda_oe_n;
  endproperty
  a_ack_takeover: assert property (p_ack_takeover)
    else $error("acknowledge without takeover");

  c_takeover: cover property (@(posedge i_clk) disable iff (i_rst) $rose(o_serial_mode));
  c_write: cover property (@(posedge i_clk) disable iff (i_rst) wr_stb);
  c_read: cover property (@(posedge i_clk) disable iff (i_rst) st == ST_RACK);
  c_illegal: cover property (@(posedge i_clk) disable iff (i_rst)
    wr_stb && shift[MODE_HI:MODE_LO] == MODE_ILLEGAL);

endmodule
`default_nettype wire

// >>> dv/scb_i2c_master.sv
`default_nettype none
module scb_i2c_master (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 12;
  // bus idle: both lines released to the pull-up level
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // start or repeated start, data falls while clock high
  task automatic start();
    tick(HALF / 2);
    o_sda = 1'b1;
    tick(HALF / 2);
    o_scl = 1'b1;
    tick(HALF);
    o_sda = 1'b0;
    tick(HALF);
    o_scl = 1'b0;
  endtask
  // one clock pulse, data set mid-low, line sampled at end of high
  task automatic xfer_bit(input logic b, output logic r);
    tick(HALF / 2);
    o_sda = b;
    tick(HALF / 2);
    o_scl = 1'b1;
    tick(HALF);
    r = i_sda;
    o_scl = 1'b0;
  endtask
  // stop, data rises while clock high
  task automatic stop();
    tick(HALF / 2);
    o_sda = 1'b0;
    tick(HALF / 2);
    o_scl = 1'b1;
    tick(HALF);
    o_sda = 1'b1;
    tick(HALF);
  endtask
  // byte out, then data released for the acknowledge
  task automatic send_byte(input logic [7:0] d, output logic ack_n);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(d[i], r);
    end
    xfer_bit(1'b1, ack_n);
  endtask
  // byte in, then our acknowledge or not-acknowledge
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(1'b1, r);
      d[i] = r;
    end
    xfer_bit(last, r);
  endtask
endmodule
`default_nettype wire

// >>> dv/scb_regbank_test.sv
`default_nettype none
module scb_regbank_test
  import scb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] OFS [8] = '{OFS_FAST_MODES, OFS_SIDE_MODES, OFS_RX_SET,
    OFS_PULSE_LO, OFS_PULSE_HI, OFS_EQ_LO, OFS_EQ_HI, OFS_TX_SET};
  localparam logic [7:0] DEF [8] = '{RST_FAST_MODES, RST_SIDE_MODES, RST_RX_SET,
    RST_PULSE, RST_PULSE, RST_EQ, RST_EQ, RST_TX_SET};
  localparam logic [7:0] WR [8] = '{8'h5A, 8'h23, 8'hFE, 8'hA5, 8'h3C, 8'h96, 8'h69, 8'hFA};
  localparam logic [7:0] RB [8] = '{8'h53, 8'h23, 8'h00, 8'hA5, 8'h3C, 8'h96, 8'h69, 8'h0A};
  localparam logic [51:0] SER_DEF = {1'b1, 6'h00, 1'b1, 6'h00, 1'b1, 32'h0, 2'h0, 2'h3};
  localparam logic [51:0] SER_WR = {1'b1, 2'h1, 4'h3, 1'b0, 2'h2, 4'h3, 1'b0,
    16'h3CA5, 16'h6996, 2'h2, 1'b1, 1'b0};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] pins = 8'h00;
  logic [2:0] strap = 3'h5;
  logic m_scl, m_sda, sda_out, sda_oe_n, sda_wire, serial_mode, ack_n;
  logic [7:0] rd;
  scb_cfg_s cfg;
  int n_errors = 0;
  int n_checks = 0;
  // clock and the pulled-up data wire
  always #5 clk = ~clk;
  assign sda_wire = m_sda & (sda_oe_n | sda_out);
  scb_regbank DUT (
    .i_clk(clk), .i_rst(rst), .i_scl(m_scl), .i_sda(sda_wire),
    .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n),
    .i_slave_addr_strap_bit2(strap[2]), .i_slave_addr_strap_bit1(strap[1]),
    .i_slave_addr_strap_bit0(strap[0]), .i_par_switch_enable_pin(pins[7]),
    .i_par_channel_select_pins(pins[6:5]), .i_par_equalizer_pin(pins[4]),
    .i_par_preemphasis_pins(pins[3:2]), .i_par_output_termination_pin(pins[1]),
    .i_par_output_current_pin(pins[0]), .o_cfg(cfg), .o_serial_mode(serial_mode)
  );
  scb_i2c_master m (.i_clk(clk), .i_sda(sda_wire), .o_scl(m_scl), .o_sda(m_sda));
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // expected configuration while the pins steer
  function automatic scb_cfg_s par_exp(input logic [7:0] p);
    scb_cfg_s c;
    c = '0;
    c.fast_path_enable = p[7];
    c.side_path_enable = p[7];
    c.fast_path_source_select = {2'h0, p[6:5]};
    c.side_path_source_select = {2'h0, p[6:5]};
    c.input_termination_select = 1'b1;
    c.equalizer_level_select = {16{p[4]}};
    c.output_preemphasis_level = p[3:2];
    c.output_termination_select = p[1];
    c.output_current_level = p[0];
    return c;
  endfunction
  task automatic reg_write(input logic [7:0] ofs, input logic [7:0] d);
    m.start();
    m.send_byte({ADDR_FIXED, strap, 1'b0}, ack_n);
    check(ack_n, 1'b0);
    m.send_byte(ofs, ack_n);
    m.send_byte(d, ack_n);
    check(ack_n, 1'b0);
    m.stop();
  endtask
  task automatic reg_read(input logic [7:0] ofs, output logic [7:0] d);
    m.start();
    m.send_byte({ADDR_FIXED, strap, 1'b0}, ack_n);
    m.send_byte(ofs, ack_n);
    m.start();
    m.send_byte({ADDR_FIXED, strap, 1'b1}, ack_n);
    check(ack_n, 1'b0);
    m.recv_byte(1'b1, d);
    m.stop();
  endtask
  task automatic settle();
    repeat (10) @(negedge clk);
  endtask
  // main sequence
  initial begin
    repeat (10) @(negedge clk);
    check(cfg, '0);
    check(sda_oe_n, 1'b1);
    rst = 1'b0;
    pins = 8'hB5;
    settle();
    check(cfg, par_exp(8'hB5));
    pins = 8'h35;
    @(negedge clk);
    pins = 8'hB5;
    settle();
    check(cfg, par_exp(8'hB5));
    pins = 8'h4A;
    settle();
    check(cfg, par_exp(8'h4A));
    $display("test parallel done");
    m.start();
    m.send_byte({ADDR_FIXED, ~strap, 1'b0}, ack_n);
    m.stop();
    check(ack_n, 1'b1);
    check(serial_mode, 1'b0);
    check(cfg, par_exp(8'h4A));
    $display("test foreign address done");
    reg_read(OFS_FAST_MODES, rd);
    check(serial_mode, 1'b1);
    check(cfg, SER_DEF);
    for (int i = 0; i < 8; i++) begin
      reg_read(OFS[i], rd);
      check(rd, DEF[i]);
    end
    $display("test takeover done");
    for (int i = 0; i < 8; i++) begin
      reg_write(OFS[i], WR[i]);
    end
    reg_write(OFS_FAST_MODES, 8'h73);
    for (int i = 0; i < 8; i++) begin
      reg_read(OFS[i], rd);
      check(rd, RB[i]);
    end
    reg_read(8'h30, rd);
    check(rd, 8'h00);
    check(cfg, SER_WR);
    $display("test serial access done");
    pins = 8'hFF;
    settle();
    check(cfg, SER_WR);
    check(serial_mode, 1'b1);
    rst = 1'b1;
    @(negedge clk);
    check(serial_mode, 1'b0);
    rst = 1'b0;
    settle();
    check(cfg, par_exp(8'hFF));
    reg_read(OFS_FAST_MODES, rd);
    check(rd, RST_FAST_MODES);
    $display("test second reset done");
    end_of_test();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (80000) @(negedge clk);
    n_errors++;
    $display("watchdog expired");
    end_of_test();
  end
endmodule
`default_nettype wire
